// ---- sim/cpu_special_registers_tb.sv ----
// Self-checking bench for the special register core.
// Assumes the program memory model stands on the table port.
`timescale 1ns/100ps
`include "csr_map.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module cpu_special_registers_tb;
	reg         clk_sys, reset_n, power_up, wdt_reset, in_powerdown;
	reg  [6:0]  mem_addr, table_low_addr;
	reg         mem_indirect, mem_wr, mem_rd, alu_wr_acc, table_read;
	reg  [7:0]  mem_wdata, pc_page;
	reg  [2:0]  alu_op, evt;
	wire [7:0]  mem_rdata, table_low_byte, accumulator_reg, status_out, bank_select;
	wire [15:0] table_addr, table_word, pc_jump_target;
	wire [6:0]  table_low_addr_out;
	wire        table_low_valid, pc_jump, dummy_cycle;
	int         num_errors, checks_done, i;
	csr_core #(.FOUR_BANKS(1)) i_csr_core (.clk_sys(clk_sys), .reset_n(reset_n),
		.power_up(power_up), .wdt_reset(wdt_reset), .in_powerdown(in_powerdown),
		.mem_addr(mem_addr), .mem_indirect(mem_indirect), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .alu_op(alu_op), .alu_wr_acc(alu_wr_acc),
		.alu_wr_mem(1'b0), .acc_load(1'b0), .watchdog_clear_instruction(evt[0]),
		.sleep_instruction(evt[1]), .watchdog_timer_timeout(evt[2]), .table_read(table_read),
		.table_low_addr(table_low_addr), .table_addr(table_addr), .table_word(table_word),
		.table_low_byte(table_low_byte), .table_low_addr_out(table_low_addr_out),
		.table_low_valid(table_low_valid), .pc_page(pc_page), .pc_jump(pc_jump),
		.pc_jump_target(pc_jump_target), .dummy_cycle(dummy_cycle),
		.accumulator_reg(accumulator_reg), .status_out(status_out), .bank_select(bank_select));
	csr_exec_model i_csr_exec_model (.table_addr(table_addr), .table_word(table_word));
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic end_of_test;
		if (num_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// One access per call; strobes drop on the edge that takes them
	task automatic acc(input [6:0] a, input [7:0] d, input w, input ind);
		@(posedge clk_sys);
		mem_addr <= a;
		mem_wdata <= d;
		mem_indirect <= ind;
		mem_wr <= w;
		mem_rd <= !w;
		@(posedge clk_sys);
		mem_wr <= 0;
		mem_rd <= 0;
		mem_indirect <= 0;
	endtask
	task automatic wr(input [6:0] a, input [7:0] d);
		acc(a, d, 1, 0);
	endtask
	task automatic rd(input [6:0] a, input [7:0] e, input ind = 0);
		acc(a, 8'h00, 0, ind);
		#1 `CHK("rdata", e, mem_rdata);
	endtask
	task automatic pulse(input [2:0] which);
		@(posedge clk_sys);
		evt <= which;
		@(posedge clk_sys);
		evt <= 3'h0;
		#1;
	endtask
	task automatic do_reset(input pu, input w, input pd);
		@(posedge clk_sys);
		reset_n <= 0;
		power_up <= pu;
		wdt_reset <= w;
		in_powerdown <= pd;
		@(posedge clk_sys);
		reset_n <= 1;
		{power_up, wdt_reset, in_powerdown} <= 3'h0;
		#1;
	endtask
	task automatic alu(input [2:0] op, input [7:0] b, input [7:0] ea, input [3:0] ef, input [3:0] m);
		@(posedge clk_sys);
		alu_op <= op;
		mem_wdata <= b;
		alu_wr_acc <= 1;
		@(posedge clk_sys);
		alu_wr_acc <= 0;
		alu_op <= `CSR_OP_NONE;
		#1 `CHK("acc", ea, accumulator_reg);
		`CHK("flags", ef, status_out[3:0] & m);
	endtask
	task automatic wait_hi(input [1:0] s);
		for (i = 0; i < 4 && (s == 0 ? pc_jump : table_low_valid) !== 1'b1; i++) @(posedge clk_sys) #1;
		if (i == 4) begin
			num_errors++;
			end_of_test();
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_pointers;
		wr(`CSR_A_PTR0, 8'h30);
		rd(`CSR_A_PTR0, 8'h30);
		wr(`CSR_A_BANK, 8'h01);
		wr(`CSR_A_IND0, 8'hA5);
		wr(`CSR_A_BANK, 8'h00);
		rd(7'h30, 8'hA5);
	endtask
	task automatic t_banks;
		wr(`CSR_A_PTR1, 8'h40);
		for (int b = 0; b < 4; b++) begin
			wr(`CSR_A_BANK, b[7:0]);
			wr(`CSR_A_IND1, 8'hC0 | b[7:0]);
		end
		for (int b = 0; b < 4; b++) begin
			wr(`CSR_A_BANK, b[7:0]);
			rd(`CSR_A_IND1, 8'hC0 | b[7:0]);
			rd(`CSR_A_PTR1, 8'h40);
		end
		rd(7'h40, 8'hC0);
		wr(`CSR_A_BANK, 8'hFF);
		rd(`CSR_A_BANK, 8'h03);
	endtask
	task automatic t_null;
		wr(`CSR_A_BANK, 8'h01);
		for (int p = 8'h60; p <= 8'h7F; p += 8'h1F) begin
			wr(`CSR_A_PTR1, p[7:0]);
			wr(`CSR_A_IND1, 8'h99);
			rd(`CSR_A_IND1, 8'h00);
		end
		acc(`CSR_A_IND1, 8'h77, 1, 1);
		rd(`CSR_A_IND1, 8'h00, 1);
		rd(`CSR_A_IND0, 8'h00, 1);
	endtask
	task automatic t_alu;
		alu(`CSR_OP_LOGIC, 8'h7F, 8'h7F, 4'h0, 4'h4);
		alu(`CSR_OP_ADD, 8'h01, 8'h80, 4'hA, 4'hF);
		alu(`CSR_OP_ADD, 8'h80, 8'h00, 4'hD, 4'hF);
		alu(`CSR_OP_SUB, 8'h01, 8'hFF, 4'h0, 4'hF);
		alu(`CSR_OP_LOGIC, 8'h05, 8'h05, 4'h0, 4'h4);
		alu(`CSR_OP_SUB, 8'h03, 8'h02, 4'h3, 4'hF);
		alu(`CSR_OP_SUB, 8'h80, 8'h82, 4'hA, 4'hF);
		alu(`CSR_OP_LOGIC, 8'h80, 8'h80, 4'h0, 4'h4);
		alu(`CSR_OP_RLC, 8'h00, 8'h00, 4'h1, 4'h1);
		alu(`CSR_OP_RLC, 8'h00, 8'h01, 4'h0, 4'h1);
		alu(`CSR_OP_RRC, 8'h00, 8'h00, 4'h1, 4'h1);
		alu(`CSR_OP_RRC, 8'h00, 8'h80, 4'h0, 4'h1);
	endtask
	task automatic t_status;
		wr(`CSR_A_STATUS, 8'hFF);
		#1 `CHK("status", 8'h0F, status_out);
		pulse(3'h2);
		wr(`CSR_A_STATUS, 8'h00);
		#1 `CHK("status", 8'h10, status_out);
		pulse(3'h4);
		`CHK("sysflags", 2'h3, status_out[5:4]);
		pulse(3'h2);
		`CHK("sysflags", 2'h1, status_out[5:4]);
		pulse(3'h1);
		`CHK("sysflags", 2'h0, status_out[5:4]);
	endtask
	task automatic t_jump_table;
		wr(`CSR_A_PCL, 8'h34);
		#1 wait_hi(0);
		`CHK("target", 16'h1234, pc_jump_target);
		@(posedge clk_sys) #1 `CHK("dummy", 1'b1, dummy_cycle);
		wr(`CSR_A_TABLE_POINTER_LOW, 8'h56);
		wr(`CSR_A_TABLE_POINTER_HIGH, 8'h9A);
		#1 `CHK("taddr", 16'h9A56, table_addr);
		@(posedge clk_sys);
		table_read <= 1;
		table_low_addr <= 7'h25;
		@(posedge clk_sys);
		table_read <= 0;
		#1 wait_hi(1);
		`CHK("tlow", 8'hA6, table_low_byte);
		`CHK("tdest", 7'h25, table_low_addr_out);
		rd(`CSR_A_TABLE_RESULT_HIGH, 8'h0C);
		rd(7'h25, 8'hA6);
	endtask
	task automatic t_resets;
		wr(`CSR_A_BANK, 8'h02);
		do_reset(0, 1, 1);
		`CHK("bank", 8'h02, bank_select);
		do_reset(0, 1, 0);
		`CHK("bank", 8'h00, bank_select);
		pulse(3'h2);
		do_reset(0, 0, 0);
		`CHK("sysflags", 2'h1, status_out[5:4]);
		do_reset(1, 0, 0);
		`CHK("status", 8'h00, status_out);
	endtask
	initial begin
		{reset_n, wdt_reset, in_powerdown, mem_indirect, mem_wr, mem_rd} = 6'h00;
		{alu_wr_acc, table_read, power_up} = 3'h1;
		{mem_addr, table_low_addr, mem_wdata, alu_op, evt} = 0;
		pc_page = 8'h12;
		num_errors = 0;
		checks_done = 0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1;
		power_up <= 0;
		#1 `CHK("bank", 8'h00, bank_select);
		`CHK("status", 8'h00, status_out);
		t_pointers();
		t_banks();
		t_null();
		t_alu();
		t_status();
		t_jump_table();
		t_resets();
		end_of_test();
	end
endmodule // cpu_special_registers_tb

// ---- sim/csr_asserts.sv ----
// Port-level checks of the special register core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`include "csr_map.vh"
module csr_asserts #(
	parameter FOUR_BANKS = 1
) (
	input wire        clk_sys,
	input wire        reset_n,
	input wire        wdt_reset,
	input wire        in_powerdown,
	input wire [6:0]  mem_addr,
	input wire        mem_indirect,
	input wire        mem_wr,
	input wire        mem_rd,
	input wire [7:0]  mem_wdata,
	input wire [7:0]  mem_rdata,
	input wire [2:0]  alu_op,
	input wire        alu_wr_acc,
	input wire        alu_wr_mem,
	input wire        watchdog_clear_instruction,
	input wire        sleep_instruction,
	input wire        watchdog_timer_timeout,
	input wire        table_read,
	input wire [15:0] table_word,
	input wire [7:0]  table_low_byte,
	input wire        table_low_valid,
	input wire [7:0]  pc_page,
	input wire        pc_jump,
	input wire [15:0] pc_jump_target,
	input wire        dummy_cycle,
	input wire [7:0]  accumulator_reg,
	input wire [7:0]  status_out,
	input wire [7:0]  bank_select
);
	wire [8:0] add_sum   = {1'b0, accumulator_reg} + {1'b0, mem_wdata};
	wire [7:0] add_res   = add_sum[7:0];
	wire       add_c     = add_sum[8];
	wire [1:0] sys_flags = status_out[5:4];
	wire [7:0] tw_low    = table_word[7:0];
	wire       keep_bank = wdt_reset & in_powerdown;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	sequence pcl_wr_s;
		mem_wr && !mem_indirect && !alu_wr_mem && mem_addr == `CSR_A_PCL;
	endsequence
	sequence jump_s;
		pc_jump && pc_jump_target == {$past(pc_page), $past(mem_wdata)} ##1 dummy_cycle && !pc_jump;
	endsequence
	bank_width_a: assert property (bank_select[7:2] == 6'h00 && (FOUR_BANKS != 0 || !bank_select[1]))
		else $error("bank select upper bits set");
	bank_reset_a: assert property ($rose(reset_n) && !$past(keep_bank) |-> bank_select == 8'h00)
		else $error("bank not cleared by reset");
	bank_keep_a: assert property ($rose(reset_n) && $past(keep_bank) && $past(reset_n, 2) |-> bank_select == $past(bank_select, 2))
		else $error("bank lost in sleeping watchdog reset");
	port_null_a: assert property (mem_rd && mem_indirect && (mem_addr == `CSR_A_IND0 || mem_addr == `CSR_A_IND1) |=> mem_rdata == 8'h00)
		else $error("port through port read not zero");
	pcl_jump_a: assert property (pcl_wr_s |=> jump_s)
		else $error("low byte write did not jump in page");
	add_flags_a: assert property (alu_wr_acc && alu_op == `CSR_OP_ADD |=> accumulator_reg == $past(add_res) && status_out[0] == $past(add_c) && status_out[2] == ($past(add_res) == 8'h00))
		else $error("add result or flags wrong");
	status_wr_a: assert property (mem_wr && !mem_indirect && mem_addr == `CSR_A_STATUS && !sleep_instruction && !watchdog_timer_timeout && !watchdog_clear_instruction |=> sys_flags == $past(sys_flags))
		else $error("status write changed system flags");
	sleep_flags_a: assert property (sleep_instruction && !watchdog_timer_timeout |=> sys_flags == 2'h1)
		else $error("sleep flags wrong");
	to_set_a: assert property (watchdog_timer_timeout |=> status_out[5])
		else $error("timeout flag not set");
	wdc_clear_a: assert property (watchdog_clear_instruction && !sleep_instruction && !watchdog_timer_timeout |=> sys_flags == 2'h0)
		else $error("watchdog clear left flags");
	table_low_a: assert property (table_read |=> table_low_valid && table_low_byte == $past(tw_low))
		else $error("table low byte wrong");
endmodule // csr_asserts
bind csr_core csr_asserts #(.FOUR_BANKS(FOUR_BANKS)) i_csr_asserts (
	.clk_sys(clk_sys), .reset_n(reset_n), .wdt_reset(wdt_reset), .in_powerdown(in_powerdown),
	.mem_addr(mem_addr), .mem_indirect(mem_indirect), .mem_wr(mem_wr), .mem_rd(mem_rd),
	.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .alu_op(alu_op), .alu_wr_acc(alu_wr_acc),
	.alu_wr_mem(alu_wr_mem), .watchdog_clear_instruction(watchdog_clear_instruction),
	.sleep_instruction(sleep_instruction), .watchdog_timer_timeout(watchdog_timer_timeout),
	.table_read(table_read), .table_word(table_word), .table_low_byte(table_low_byte),
	.table_low_valid(table_low_valid), .pc_page(pc_page), .pc_jump(pc_jump),
	.pc_jump_target(pc_jump_target), .dummy_cycle(dummy_cycle),
	.accumulator_reg(accumulator_reg), .status_out(status_out), .bank_select(bank_select));

// ---- sim/csr_exec_model.sv ----
// Program memory seen by the table read port.
// Assumes the core presents the table address combinationally.
`timescale 1ns/100ps
module csr_exec_model (
	input  wire [15:0] table_addr,
	output wire [15:0] table_word
);
	// Each half takes the other pointer byte, so a swapped or stale byte shows
	assign table_word = {table_addr[7:0], table_addr[15:8]} ^ 16'h5A3C;
endmodule // csr_exec_model

// ---- src/csr_addr_resolve.v ----
// Resolves a data-memory access from instruction address and pointer state.
// Assumes the bank field is already width-limited by the variant.
`timescale 1ns/100ps
`include "csr_map.vh"
module csr_addr_resolve (
	addr,
	indirect_sel,
	pointer_zero,
	pointer_one,
	bank_sel,
	eff_addr,
	eff_bank,
	is_null
);
	input  wire [6:0] addr;
	input  wire       indirect_sel;
	input  wire [7:0] pointer_zero;
	input  wire [7:0] pointer_one;
	input  wire [1:0] bank_sel;
	output reg  [6:0] eff_addr;
	output reg  [1:0] eff_bank;
	output reg        is_null;

	function is_port;
		input [6:0] a;
		begin
			is_port = (a == `CSR_A_IND0) || (a == `CSR_A_IND1);
		end
	endfunction

	always @* begin
		eff_addr = addr;
		eff_bank = `CSR_BANK0;
		is_null  = 1'b0;
		if (!indirect_sel && addr == `CSR_A_IND0) begin
			eff_addr = pointer_zero[6:0];
			eff_bank = `CSR_BANK0;
		end else if (!indirect_sel && addr == `CSR_A_IND1) begin
			eff_addr = pointer_one[6:0];
			eff_bank = bank_sel;
		end
		if (!indirect_sel && is_port(addr) && is_port(eff_addr))
			is_null = 1'b1;
		if (eff_bank == `CSR_BANK1 && eff_addr >= `CSR_B1_HOLE_LO &&
		    eff_addr <= `CSR_B1_HOLE_HI)
			is_null = 1'b1;
	end
endmodule // csr_addr_resolve

// ---- src/csr_core.v ----
// Core special function registers: pointers, bank select, accumulator,
// program-counter low byte, table registers, status and banked data memory.
// Assumes the execution logic issues one access per clk_sys cycle.
//
// Contract
// - Indirect port access goes to pointed location
// - Pointer zero bank 0, pointer one banked
// - Port via port reads zero, writes nothing
// - Pointers are ordinary read-write storage
// - Direct data accesses always hit bank 0
// - Special registers same in every bank
// - Four-bank: two-bit field, upper bits zero
// - Two-bank: one bit, upper bits zero
// - Resets clear bank, except sleeping watchdog
// - Bank 1 60H-7FH reads zero
// - Register moves pass through accumulator
// - Low byte write jumps in page, dummy cycle
// - Table read: high byte to result register
// - Status writes keep timeout, powerdown flags
// - Carry from add, no-borrow, rotates
// - Half carry from low nibble
// - Zero flag on zero result
// - Overflow on carry-in xor carry-out MSB
// - Powerdown: clear power-up/clear, set sleep
// - Timeout: clear power-up/clear/sleep, set timeout
// - Status never auto-saved on call
`timescale 1ns/100ps
`include "csr_map.vh"
module csr_core #(
	parameter FOUR_BANKS = 1
) (
	clk_sys,
	reset_n,
	power_up,
	wdt_reset,
	in_powerdown,
	mem_addr,
	mem_indirect,
	mem_wr,
	mem_rd,
	mem_wdata,
	mem_rdata,
	alu_op,
	alu_wr_acc,
	alu_wr_mem,
	acc_load,
	watchdog_clear_instruction,
	sleep_instruction,
	watchdog_timer_timeout,
	table_read,
	table_low_addr,
	table_addr,
	table_word,
	table_low_byte,
	table_low_addr_out,
	table_low_valid,
	pc_page,
	pc_jump,
	pc_jump_target,
	dummy_cycle,
	accumulator_reg,
	status_out,
	bank_select
);
	input  wire        clk_sys;
	input  wire        reset_n;
	input  wire        power_up;
	input  wire        wdt_reset;
	input  wire        in_powerdown;
	input  wire [6:0]  mem_addr;
	input  wire        mem_indirect;
	input  wire        mem_wr;
	input  wire        mem_rd;
	input  wire [7:0]  mem_wdata;
	output reg  [7:0]  mem_rdata;
	input  wire [2:0]  alu_op;
	input  wire        alu_wr_acc;
	input  wire        alu_wr_mem;
	input  wire        acc_load;
	input  wire        watchdog_clear_instruction;
	input  wire        sleep_instruction;
	input  wire        watchdog_timer_timeout;
	input  wire        table_read;
	input  wire [6:0]  table_low_addr;
	output wire [15:0] table_addr;
	input  wire [15:0] table_word;
	output reg  [7:0]  table_low_byte;
	output reg  [6:0]  table_low_addr_out;
	output reg         table_low_valid;
	input  wire [7:0]  pc_page;
	output reg         pc_jump;
	output reg  [15:0] pc_jump_target;
	output reg         dummy_cycle;
	output wire [7:0]  accumulator_reg;
	output wire [7:0]  status_out;
	output wire [7:0]  bank_select;

	////////////////////////////////////////////////////////////////////////////////
	// State

	reg [7:0] pointer_zero_reg;
	reg [7:0] pointer_one_reg;
	reg [1:0] bank_sel_reg;
	reg [7:0] acc_reg;
	reg [7:0] pcl_reg;
	reg [7:0] table_pointer_low_reg;
	reg [7:0] table_pointer_high_reg;
	reg [7:0] table_result_high_reg;
	reg       carry_reg;
	reg       half_carry_reg;
	reg       zero_reg;
	reg       overflow_reg;
	reg       powerdown_flag_reg;
	reg       watchdog_timeout_flag_reg;
	// Banked general memory, banks 0..3 of 128 bytes
	reg [7:0] dmem [0:`CSR_DM_DEPTH-1];

	wire [6:0] eff_addr;
	wire [1:0] eff_bank;
	wire       is_null;
	wire [7:0] alu_result;
	wire       alu_c;
	wire       alu_ac;
	wire       alu_z;
	wire       alu_ov;
	wire       alu_valid;
	wire [1:0] bank_mask;
	wire       is_sfr;
	wire [`CSR_DM_AW-1:0] dm_index;
	reg  [7:0] sfr_rdata;
	wire [7:0] wr_value;
	wire       do_wr;

	////////////////////////////////////////////////////////////////////////////////
	// Address resolution and flags

	csr_addr_resolve u_resolve (
		.addr         (mem_addr),
		.indirect_sel (mem_indirect),
		.pointer_zero (pointer_zero_reg),
		.pointer_one  (pointer_one_reg),
		.bank_sel     (bank_sel_reg),
		.eff_addr     (eff_addr),
		.eff_bank     (eff_bank),
		.is_null      (is_null)
	);

	// The ALU always works on the accumulator and one memory operand
	csr_flag_unit u_flags (
		.op             (alu_op),
		.opa            (acc_reg),
		.opb            (mem_wdata),
		.carry_in       (carry_reg),
		.result         (alu_result),
		.carry_out      (alu_c),
		.half_carry_out (alu_ac),
		.zero_out       (alu_z),
		.overflow_out   (alu_ov),
		.flags_valid    (alu_valid)
	);

	assign bank_mask = (FOUR_BANKS != 0) ? 2'h3 : 2'h1;
	// Special registers ignore bank selection entirely
	assign is_sfr    = (eff_addr <= `CSR_SFR_TOP);
	assign dm_index  = {eff_bank, eff_addr};
	// A memory write takes either the ALU result or the raw data
	assign wr_value  = alu_wr_mem ? alu_result : mem_wdata;
	assign do_wr     = mem_wr && !is_null;

	assign accumulator_reg = acc_reg;
	assign bank_select     = {6'h00, bank_sel_reg & bank_mask};
	assign status_out      = {2'h0, watchdog_timeout_flag_reg, powerdown_flag_reg,
	                          overflow_reg, zero_reg, half_carry_reg, carry_reg};
	assign table_addr      = {table_pointer_high_reg, table_pointer_low_reg};

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	always @* begin
		sfr_rdata = `CSR_ZERO8;
		case (eff_addr)
		`CSR_A_PTR0:   sfr_rdata = pointer_zero_reg;
		`CSR_A_PTR1:   sfr_rdata = pointer_one_reg;
		`CSR_A_BANK:   sfr_rdata = bank_select;
		`CSR_A_ACC:    sfr_rdata = acc_reg;
		`CSR_A_PCL:    sfr_rdata = pcl_reg;
		`CSR_A_TABLE_POINTER_LOW:   sfr_rdata = table_pointer_low_reg;
		`CSR_A_TABLE_RESULT_HIGH:   sfr_rdata = table_result_high_reg;
		`CSR_A_TABLE_POINTER_HIGH:   sfr_rdata = table_pointer_high_reg;
		`CSR_A_STATUS: sfr_rdata = status_out;
		default:       sfr_rdata = `CSR_ZERO8;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!reset_n)
			mem_rdata <= `CSR_ZERO8;
		else if (mem_rd) begin
			if (is_null)
				mem_rdata <= `CSR_ZERO8;
			else if (is_sfr)
				mem_rdata <= sfr_rdata;
			else
				mem_rdata <= dmem[dm_index];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// General data memory

	// No reset on the array: RAM contents are undefined after power-up
	always @(posedge clk_sys) begin
		if (do_wr && !is_sfr)
			dmem[dm_index] <= wr_value;
		if (table_read && table_low_addr > `CSR_SFR_TOP)
			dmem[{`CSR_BANK0, table_low_addr}] <= table_word[7:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Special registers

	// Memory-to-memory moves do not exist; results land in acc or memory
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pointer_zero_reg       <= `CSR_ZERO8;
			pointer_one_reg        <= `CSR_ZERO8;
			acc_reg                <= `CSR_ZERO8;
			pcl_reg                <= `CSR_ZERO8;
			table_pointer_low_reg  <= `CSR_ZERO8;
			table_pointer_high_reg <= `CSR_ZERO8;
			table_result_high_reg  <= `CSR_ZERO8;
		end else begin
			if (alu_wr_acc && alu_valid)
				acc_reg <= alu_result;
			else if (acc_load)
				acc_reg <= mem_rdata;
			if (table_read)
				table_result_high_reg <= table_word[15:8];
			if (pc_jump)
				pcl_reg <= pc_jump_target[7:0];
			if (do_wr && is_sfr) begin
				case (eff_addr)
				`CSR_A_PTR0: pointer_zero_reg       <= wr_value;
				`CSR_A_PTR1: pointer_one_reg        <= wr_value;
				`CSR_A_ACC:  acc_reg                <= wr_value;
				`CSR_A_PCL:  pcl_reg                <= wr_value;
				`CSR_A_TABLE_POINTER_LOW: table_pointer_low_reg  <= wr_value;
				`CSR_A_TABLE_POINTER_HIGH: table_pointer_high_reg <= wr_value;
				`CSR_A_TABLE_RESULT_HIGH: table_result_high_reg  <= wr_value;
				default:     pcl_reg                <= pcl_reg;
				endcase
			end
		end
	end

	// Bank survives only a watchdog reset taken while asleep
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			if (!(wdt_reset && in_powerdown))
				bank_sel_reg <= `CSR_BANK0;
		end else if (do_wr && is_sfr && eff_addr == `CSR_A_BANK)
			bank_sel_reg <= wr_value[1:0] & bank_mask;
	end

	// Jump within the page; one dummy cycle follows the write
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pc_jump        <= 1'b0;
			pc_jump_target <= 16'h0000;
			dummy_cycle    <= 1'b0;
		end else begin
			pc_jump     <= do_wr && is_sfr && eff_addr == `CSR_A_PCL;
			dummy_cycle <= pc_jump;
			if (do_wr && is_sfr && eff_addr == `CSR_A_PCL)
				pc_jump_target <= {pc_page, wr_value};
		end
	end

	// Table low byte destination is chosen by the program
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			table_low_byte     <= `CSR_ZERO8;
			table_low_addr_out <= 7'h00;
			table_low_valid    <= 1'b0;
		end else begin
			table_low_valid <= table_read;
			if (table_read) begin
				table_low_byte     <= table_word[7:0];
				table_low_addr_out <= table_low_addr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags

	// Status is a plain register; no stack path exists for it
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			carry_reg      <= 1'b0;
			half_carry_reg <= 1'b0;
			zero_reg       <= 1'b0;
			overflow_reg   <= 1'b0;
		end else if (alu_valid && (alu_wr_acc || alu_wr_mem)) begin
			carry_reg <= alu_c;
			zero_reg  <= alu_z;
			if (alu_op == `CSR_OP_ADD || alu_op == `CSR_OP_SUB) begin
				half_carry_reg <= alu_ac;
				overflow_reg   <= alu_ov;
			end
		end else if (do_wr && is_sfr && eff_addr == `CSR_A_STATUS) begin
			carry_reg      <= wr_value[`CSR_ST_C];
			half_carry_reg <= wr_value[`CSR_ST_AC];
			zero_reg       <= wr_value[`CSR_ST_Z];
			overflow_reg   <= wr_value[`CSR_ST_OV];
		end
	end

	// Timeout set wins over a same-cycle clear
	always @(posedge clk_sys) begin
		if (!reset_n && power_up) begin
			powerdown_flag_reg        <= 1'b0;
			watchdog_timeout_flag_reg <= 1'b0;
		end else begin
			if (sleep_instruction)
				powerdown_flag_reg <= 1'b1;
			else if (watchdog_clear_instruction)
				powerdown_flag_reg <= 1'b0;
			if (watchdog_timer_timeout)
				watchdog_timeout_flag_reg <= 1'b1;
			else if (watchdog_clear_instruction || sleep_instruction)
				watchdog_timeout_flag_reg <= 1'b0;
		end
	end
endmodule // csr_core

// ---- src/csr_flag_unit.v ----
// Arithmetic flag generation for add, subtract, logic and rotate-through-carry.
// Assumes operands come from the execution logic on the same clock.
`timescale 1ns/100ps
`include "csr_map.vh"
module csr_flag_unit (
	op,
	opa,
	opb,
	carry_in,
	result,
	carry_out,
	half_carry_out,
	zero_out,
	overflow_out,
	flags_valid
);
	input  wire [2:0] op;
	input  wire [7:0] opa;
	input  wire [7:0] opb;
	input  wire       carry_in;
	output reg  [7:0] result;
	output reg        carry_out;
	output reg        half_carry_out;
	output reg        zero_out;
	output reg        overflow_out;
	output reg        flags_valid;

	reg [8:0] sum;
	reg [4:0] nib;
	reg [7:0] sum7;

	always @* begin
		sum            = 9'h000;
		nib            = 5'h00;
		sum7           = 8'h00;
		result         = `CSR_ZERO8;
		carry_out      = carry_in;
		half_carry_out = 1'b0;
		overflow_out   = 1'b0;
		flags_valid    = 1'b1;
		case (op)
		`CSR_OP_ADD: begin
			sum            = {1'b0, opa} + {1'b0, opb};
			nib            = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
			sum7           = {1'b0, opa[6:0]} + {1'b0, opb[6:0]};
			result         = sum[7:0];
			carry_out      = sum[8];
			half_carry_out = nib[4];
			overflow_out   = sum7[7] ^ sum[8];
		end
		`CSR_OP_SUB: begin
			// Subtraction as a + ~b + 1: carry set means no borrow
			sum            = {1'b0, opa} + {1'b0, ~opb} + 9'h001;
			nib            = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + 5'h01;
			sum7           = {1'b0, opa[6:0]} + {1'b0, ~opb[6:0]} + 8'h01;
			result         = sum[7:0];
			carry_out      = sum[8];
			half_carry_out = nib[4];
			overflow_out   = sum7[7] ^ sum[8];
		end
		`CSR_OP_LOGIC: begin
			result = opb;
		end
		`CSR_OP_RLC: begin
			result    = {opa[6:0], carry_in};
			carry_out = opa[7];
		end
		`CSR_OP_RRC: begin
			result    = {carry_in, opa[7:1]};
			carry_out = opa[0];
		end
		default: begin
			flags_valid = 1'b0;
		end
		endcase
		zero_out = (result == `CSR_ZERO8);
	end
endmodule // csr_flag_unit

// ---- src/csr_map.vh ----
// Address map, field positions and reset values of the core special registers.
// Assumes inclusion by bare name from every design file of this block.
`ifndef CSR_MAP_VH
`define CSR_MAP_VH
`define CSR_A_IND0     7'h00
`define CSR_A_PTR0     7'h01
`define CSR_A_IND1     7'h02
`define CSR_A_PTR1     7'h03
`define CSR_A_BANK     7'h04
`define CSR_A_ACC      7'h05
`define CSR_A_PCL      7'h06
`define CSR_A_TABLE_POINTER_LOW     7'h07
`define CSR_A_TABLE_RESULT_HIGH     7'h08
`define CSR_A_TABLE_POINTER_HIGH     7'h09
`define CSR_A_STATUS   7'h0A
`define CSR_SFR_TOP    7'h1F
`define CSR_B1_HOLE_LO 7'h60
`define CSR_B1_HOLE_HI 7'h7F
`define CSR_ZERO8      8'h00
`define CSR_BANK0      2'h0
`define CSR_BANK1      2'h1
`define CSR_ST_C       0
`define CSR_ST_AC      1
`define CSR_ST_Z       2
`define CSR_ST_OV      3
`define CSR_ST_PDF     4
`define CSR_ST_TO      5
`define CSR_ST_ARITH   4'hF
`define CSR_OP_NONE    3'h0
`define CSR_OP_ADD     3'h1
`define CSR_OP_SUB     3'h2
`define CSR_OP_LOGIC   3'h3
`define CSR_OP_RLC     3'h4
`define CSR_OP_RRC     3'h5
`define CSR_DM_DEPTH   512
`define CSR_DM_AW      9
`endif
